// [include/gauge_regs_pkg.sv]
package gauge_regs_pkg;

	// ----------------------------------------------------------------
	// Register addresses and layout
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_CONFIG_ADDR = 8'h00;
	localparam logic [7:0] CONTROL_STATUS_ADDR = 8'h01;

	localparam int MODE_POWER_SAVING_BIT = 0;
	localparam int MODE_VOLT_CLEAR_BIT = 1;
	localparam int MODE_COUL_CLEAR_BIT = 2;
	localparam int MODE_ALARM_ENABLE_BIT = 3;
	localparam int MODE_OPERATE_BIT = 4;
	localparam int MODE_COUL_FORCE_BIT = 5;
	localparam int MODE_VOLT_FORCE_BIT = 6;

	localparam int CTRL_ALARM_LEVEL_BIT = 0;
	localparam int CTRL_COUNT_CLEAR_BIT = 1;
	localparam int CTRL_VOLT_SOURCE_BIT = 2;
	localparam int CTRL_BATTERY_LOSS_BIT = 3;
	localparam int CTRL_POWER_ON_BIT = 4;
	localparam int CTRL_LOW_CHARGE_BIT = 5;
	localparam int CTRL_LOW_VOLTAGE_BIT = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic POWER_SAVING_RESET = 1'b1;
	localparam logic ALARM_ENABLE_RESET = 1'b1;
	localparam logic OPERATE_RESET = 1'b0;
	localparam logic ALARM_DRIVE_RESET = 1'b1;
	localparam logic POWER_ON_FLAG_RESET = 1'b1;
	localparam logic [2:0] PIN_SYNC_RESET = 3'h7;

endpackage

// [rtl/gauge_mode_control_registers.sv]
`timescale 1ns/10ps
// Functional notes
// - Mode bit 0 selects power-saving; resets 1
// - Mode bit 1 clears voltage correction, self-clears once bit 4 is set
// - Mode bit 2 clears coulomb correction, self-clears once bit 4 is set
// - Mode bit 3 enables alarm; resets 1
// - Mode bit 4 zero holds standby freeze
// - Mode bit 5 zeroes relaxation counter, self-clears
// - Mode bit 6 loads relaxation maximum, self-clears
// - Control bit 0 reads sampled alarm pin
// - Control bit 0 written 0 forces pin low
// - Control bit 1 resets conversion counter, self-clears
// - Control bit 2 shows voltage source; resets 0
// - Battery loss flag: device sets, host zeroes
// - Control bit 4 reads power-on flag, default 1
// - Control bit 4 write drives soft reset
// - Low-charge flag sticky until host writes 0
// - Low-voltage flag sticky until host writes 0
// - All registers reset; power-on flag records it
module gauge_mode_control_registers (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	output logic [7:0] reg_rdata_o,
	input wire logic alarm_pin_i,
	output logic alarm_pin_o,
	output logic alarm_pin_oe_n_o,
	input wire logic battery_loss_event_i,
	input wire logic low_charge_event_i,
	input wire logic low_voltage_event_i,
	input wire logic voltage_source_active_i,
	output logic power_saving_select_o,
	output logic alarm_function_enable_o,
	output logic gauge_operate_o,
	output logic voltage_correction_clear_o,
	output logic coulomb_correction_clear_o,
	output logic coulomb_force_o,
	output logic voltage_force_o,
	output logic conversion_count_clear_o,
	output logic soft_reset_o
);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic mode_write;
	logic ctrl_write;

	always_comb begin
		mode_write = 1'b0;
		ctrl_write = 1'b0;
		if (reg_write_i && reg_addr_i == gauge_regs_pkg::MODE_CONFIG_ADDR) begin
			mode_write = 1'b1;
		end else if (reg_write_i && reg_addr_i == gauge_regs_pkg::CONTROL_STATUS_ADDR) begin
			ctrl_write = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Mode register
	// ----------------------------------------------------------------
	logic power_saving_select_reg;
	logic alarm_function_enable_reg;
	logic gauge_operate_reg;
	logic voltage_correction_clear_reg;
	logic coulomb_correction_clear_reg;
	logic coulomb_force_reg;
	logic voltage_force_reg;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			power_saving_select_reg <= gauge_regs_pkg::POWER_SAVING_RESET;
			alarm_function_enable_reg <= gauge_regs_pkg::ALARM_ENABLE_RESET;
			gauge_operate_reg <= gauge_regs_pkg::OPERATE_RESET;
		end else if (mode_write) begin
			power_saving_select_reg <= reg_wdata_i[gauge_regs_pkg::MODE_POWER_SAVING_BIT];
			alarm_function_enable_reg <= reg_wdata_i[gauge_regs_pkg::MODE_ALARM_ENABLE_BIT];
			gauge_operate_reg <= reg_wdata_i[gauge_regs_pkg::MODE_OPERATE_BIT];
		end
	end

	// The correction clears linger while in standby so the frozen gauge
	// still sees them once it starts; they drop on the first running cycle.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			voltage_correction_clear_reg <= 1'b0;
			coulomb_correction_clear_reg <= 1'b0;
		end else if (mode_write) begin
			voltage_correction_clear_reg <= reg_wdata_i[gauge_regs_pkg::MODE_VOLT_CLEAR_BIT];
			coulomb_correction_clear_reg <= reg_wdata_i[gauge_regs_pkg::MODE_COUL_CLEAR_BIT];
		end else if (gauge_operate_reg) begin
			voltage_correction_clear_reg <= 1'b0;
			coulomb_correction_clear_reg <= 1'b0;
		end
	end

	// Force strobes last exactly one cycle after the write.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			coulomb_force_reg <= 1'b0;
			voltage_force_reg <= 1'b0;
		end else begin
			coulomb_force_reg <= mode_write && reg_wdata_i[gauge_regs_pkg::MODE_COUL_FORCE_BIT];
			voltage_force_reg <= mode_write && reg_wdata_i[gauge_regs_pkg::MODE_VOLT_FORCE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	logic alarm_pin_level_drive_reg;
	logic conversion_count_clear_reg;
	logic voltage_source_indicator_reg;
	logic battery_loss_flag_reg;
	logic power_on_flag_reg;
	logic soft_reset_reg;
	logic low_charge_flag_reg;
	logic low_voltage_flag_reg;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_pin_level_drive_reg <= gauge_regs_pkg::ALARM_DRIVE_RESET;
		end else if (ctrl_write) begin
			alarm_pin_level_drive_reg <= reg_wdata_i[gauge_regs_pkg::CTRL_ALARM_LEVEL_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			conversion_count_clear_reg <= 1'b0;
		end else begin
			conversion_count_clear_reg <= ctrl_write
				&& reg_wdata_i[gauge_regs_pkg::CTRL_COUNT_CLEAR_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			voltage_source_indicator_reg <= 1'b0;
		end else begin
			voltage_source_indicator_reg <= voltage_source_active_i;
		end
	end

	// Set wins over a clearing write in the same cycle, so no event is lost.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			battery_loss_flag_reg <= 1'b0;
		end else if (battery_loss_event_i) begin
			battery_loss_flag_reg <= 1'b1;
		end else if (ctrl_write && !reg_wdata_i[gauge_regs_pkg::CTRL_BATTERY_LOSS_BIT]) begin
			battery_loss_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_charge_flag_reg <= 1'b0;
		end else if (low_charge_event_i) begin
			low_charge_flag_reg <= 1'b1;
		end else if (ctrl_write && !reg_wdata_i[gauge_regs_pkg::CTRL_LOW_CHARGE_BIT]) begin
			low_charge_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_voltage_flag_reg <= 1'b0;
		end else if (low_voltage_event_i) begin
			low_voltage_flag_reg <= 1'b1;
		end else if (ctrl_write && !reg_wdata_i[gauge_regs_pkg::CTRL_LOW_VOLTAGE_BIT]) begin
			low_voltage_flag_reg <= 1'b0;
		end
	end

	// The hard reset sets the power-on flag; software drives it afterwards.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			power_on_flag_reg <= gauge_regs_pkg::POWER_ON_FLAG_RESET;
		end else if (ctrl_write) begin
			power_on_flag_reg <= reg_wdata_i[gauge_regs_pkg::CTRL_POWER_ON_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			soft_reset_reg <= 1'b0;
		end else begin
			soft_reset_reg <= ctrl_write && reg_wdata_i[gauge_regs_pkg::CTRL_POWER_ON_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Alarm pin
	// ----------------------------------------------------------------
	logic [2:0] alarm_sync_reg;
	logic alarm_level_reg;
	logic alarm_drive_low_reg;

	// Three stages; the level only moves when the second and third agree.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_sync_reg <= gauge_regs_pkg::PIN_SYNC_RESET;
		end else begin
			alarm_sync_reg <= {alarm_sync_reg[1:0], alarm_pin_i};
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_level_reg <= 1'b1;
		end else if (alarm_sync_reg[1] == alarm_sync_reg[2]) begin
			alarm_level_reg <= alarm_sync_reg[2];
		end
	end

	// Open drain: the pin is only ever pulled low, never driven high.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_drive_low_reg <= 1'b0;
		end else begin
			alarm_drive_low_reg <= !alarm_pin_level_drive_reg
				|| (alarm_function_enable_reg
				&& (low_charge_flag_reg || low_voltage_flag_reg));
		end
	end

	assign alarm_pin_o = 1'b0;
	assign alarm_pin_oe_n_o = !alarm_drive_low_reg;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [7:0] mode_rdata;
	logic [7:0] ctrl_rdata;

	always_comb begin
		mode_rdata = 8'h00;
		mode_rdata[gauge_regs_pkg::MODE_POWER_SAVING_BIT] = power_saving_select_reg;
		mode_rdata[gauge_regs_pkg::MODE_VOLT_CLEAR_BIT] = voltage_correction_clear_reg;
		mode_rdata[gauge_regs_pkg::MODE_COUL_CLEAR_BIT] = coulomb_correction_clear_reg;
		mode_rdata[gauge_regs_pkg::MODE_ALARM_ENABLE_BIT] = alarm_function_enable_reg;
		mode_rdata[gauge_regs_pkg::MODE_OPERATE_BIT] = gauge_operate_reg;
		ctrl_rdata = 8'h00;
		ctrl_rdata[gauge_regs_pkg::CTRL_ALARM_LEVEL_BIT] = alarm_level_reg;
		ctrl_rdata[gauge_regs_pkg::CTRL_VOLT_SOURCE_BIT] = voltage_source_indicator_reg;
		ctrl_rdata[gauge_regs_pkg::CTRL_BATTERY_LOSS_BIT] = battery_loss_flag_reg;
		ctrl_rdata[gauge_regs_pkg::CTRL_POWER_ON_BIT] = power_on_flag_reg;
		ctrl_rdata[gauge_regs_pkg::CTRL_LOW_CHARGE_BIT] = low_charge_flag_reg;
		ctrl_rdata[gauge_regs_pkg::CTRL_LOW_VOLTAGE_BIT] = low_voltage_flag_reg;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_addr_i == gauge_regs_pkg::MODE_CONFIG_ADDR) begin
			reg_rdata_o <= mode_rdata;
		end else if (reg_addr_i == gauge_regs_pkg::CONTROL_STATUS_ADDR) begin
			reg_rdata_o <= ctrl_rdata;
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign power_saving_select_o = power_saving_select_reg;
	assign alarm_function_enable_o = alarm_function_enable_reg;
	assign gauge_operate_o = gauge_operate_reg;
	assign voltage_correction_clear_o = voltage_correction_clear_reg;
	assign coulomb_correction_clear_o = coulomb_correction_clear_reg;
	assign coulomb_force_o = coulomb_force_reg;
	assign voltage_force_o = voltage_force_reg;
	assign conversion_count_clear_o = conversion_count_clear_reg;
	assign soft_reset_o = soft_reset_reg;

endmodule

// [verification/gauge_host_model.sv]
`timescale 1ns/10ps
module gauge_host_model (
	input wire logic clk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_write_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_write_o = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_write_o = 1'b1;
		@(negedge clk_i);
		reg_write_o = 1'b0;
		// Released data is inverted so a stale byte can never look valid.
		reg_wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		@(negedge clk_i);
		d = reg_rdata_i;
	endtask
endmodule

// [verification/gauge_mode_control_properties.sv]
`timescale 1ns/10ps
module gauge_mode_control_properties (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic alarm_pin_oe_n_o,
	input wire logic low_charge_event_i,
	input wire logic power_saving_select_o,
	input wire logic alarm_function_enable_o,
	input wire logic gauge_operate_o,
	input wire logic coulomb_force_o,
	input wire logic voltage_force_o,
	input wire logic conversion_count_clear_o,
	input wire logic soft_reset_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	wire wr_m = reg_write_i && reg_addr_i == 8'h00;
	wire wr_c = reg_write_i && reg_addr_i == 8'h01;
	a_bit7_zero: assert property (reg_rdata_o[7] == 1'b0)
		else $error("bit 7 read as one");
	a_count_clear: assert property (wr_c && reg_wdata_i[1] |=> conversion_count_clear_o)
		else $error("count clear missing");
	a_count_cause: assert property (conversion_count_clear_o |-> $past(wr_c && reg_wdata_i[1]))
		else $error("count clear without write");
	a_soft_reset: assert property (wr_c && reg_wdata_i[4] |=> soft_reset_o)
		else $error("soft reset missing");
	a_coul_force: assert property (wr_m && reg_wdata_i[5] |=> coulomb_force_o)
		else $error("coulomb force missing");
	a_volt_force: assert property (wr_m && reg_wdata_i[6] |=> voltage_force_o)
		else $error("voltage force missing");
	a_mode_levels: assert property (wr_m |=> {gauge_operate_o, alarm_function_enable_o,
		power_saving_select_o} == $past({reg_wdata_i[4], reg_wdata_i[3], reg_wdata_i[0]}))
		else $error("mode level wrong");
	a_force_low: assert property (wr_c && !reg_wdata_i[0] |-> ##[1:3] !alarm_pin_oe_n_o)
		else $error("pin not forced low");
	a_alarm_flag: assert property (alarm_function_enable_o && low_charge_event_i
		|-> ##[1:3] !alarm_pin_oe_n_o) else $error("alarm not driven");
	// The past reset term keeps the check off the first edge after release.
	a_mode_read: assert property ($past(resetn_i) && $past(reg_addr_i) == 8'h00
		&& !$past(reg_write_i) |-> {reg_rdata_o[4:3], reg_rdata_o[0]} == {gauge_operate_o,
		alarm_function_enable_o, power_saving_select_o}) else $error("mode read wrong");
endmodule
bind gauge_mode_control_registers gauge_mode_control_properties u_props (.*);

// [verification/gauge_mode_control_registers_test.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module gauge_mode_control_registers_test;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic vsrc = 1'b0;
	logic [2:0] ev_bits = 3'h0;
	logic [7:0] addr, wdata, rdata, m, r;
	logic wr, drv, pf, blf, f5, f6, pin_o, oe_n;
	logic [4:0] mode_out;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 27892;
	// Open drain with a pull-up: released means high.
	wire alarm_pin = oe_n ? 1'b1 : pin_o;
	always #5 clk_i = ~clk_i;
	gauge_host_model u_host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_write_o(wr));
	gauge_mode_control_registers u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr), .reg_rdata_o(rdata),
		.alarm_pin_i(alarm_pin), .alarm_pin_o(pin_o), .alarm_pin_oe_n_o(oe_n),
		.battery_loss_event_i(ev_bits[0]), .low_charge_event_i(ev_bits[1]),
		.low_voltage_event_i(ev_bits[2]), .voltage_source_active_i(vsrc),
		.power_saving_select_o(mode_out[0]), .voltage_correction_clear_o(mode_out[1]),
		.coulomb_correction_clear_o(mode_out[2]), .alarm_function_enable_o(mode_out[3]),
		.gauge_operate_o(mode_out[4]), .coulomb_force_o(), .voltage_force_o(),
		.conversion_count_clear_o(), .soft_reset_o());
	task automatic results();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			results();
		end
	end
	task automatic rst();
		@(negedge clk_i);
		resetn_i = 1'b0;
		repeat (3) @(negedge clk_i);
		resetn_i = 1'b1;
		m = 8'h09;
		{drv, pf, blf, f5, f6} = 5'b11000;
	endtask
	task automatic wm(input logic [7:0] d);
		u_host.wr(8'h00, d);
		m = d & (d[4] ? 8'h19 : 8'h1f);
	endtask
	task automatic wc(input logic [7:0] d);
		u_host.wr(8'h01, d);
		{drv, pf} = {d[0], d[4]};
		{blf, f5, f6} = {blf & d[3], f5 & d[5], f6 & d[6]};
	endtask
	task automatic ev(input int k);
		@(negedge clk_i);
		ev_bits[k] = 1'b1;
		@(negedge clk_i);
		ev_bits = 3'h0;
		{blf, f5, f6} = {blf, f5, f6} | (3'b100 >> k);
	endtask
	// Six cycles cover the pin synchroniser and the registered source bit.
	task automatic check();
		logic p;
		repeat (6) @(negedge clk_i);
		p = drv && !(m[3] && (f5 || f6));
		u_host.rd(8'h00, r);
		`CHK(r, m)
		`CHK(mode_out, m[4:0])
		u_host.rd(8'h01, r);
		`CHK(r, {1'b0, f6, f5, pf, blf, vsrc, 1'b0, p})
		`CHK(oe_n, p)
		u_host.rd(8'h05, r);
		`CHK(r, 8'h00)
	endtask
	initial begin
		rst();
		check();
		for (int i = 0; i < 8; i++) begin
			vsrc = 1'($random(seed));
			wm(8'($random(seed)));
			check();
		end
		wm(8'h06);
		check();
		wm(8'h1e);
		check();
		wc(8'h13);
		check();
		wc(8'h00);
		check();
		wm(8'h18);
		wc(8'h01);
		for (int k = 0; k < 3; k++)
			ev(k);
		check();
		wc(8'h79);
		check();
		wc(8'h01);
		check();
		wm(8'h10);
		ev(1);
		check();
		rst();
		check();
		results();
	end
endmodule
